// >>> design/csb_regs.vh
// Constants for the compare, skip and branch execution unit.
// Assumes the core decodes each instruction into a command code and operand fields.
`ifndef CSB_REGS_VH
`define CSB_REGS_VH

// ==========================================================
// Command codes
`define CSB_CMD_W                 4
`define CSB_CMD_POINTER_CALL      4'h1
`define CSB_CMD_COMPARE_SKIP_EQ   4'h2
`define CSB_CMD_COMPARE_IMM       4'h3
`define CSB_CMD_SKIP_REG_CLEAR    4'h4
`define CSB_CMD_SKIP_REG_SET      4'h5
`define CSB_CMD_SKIP_IO_SET       4'h6
`define CSB_CMD_BRANCH_FLAG_SET   4'h7
`define CSB_CMD_BRANCH_FLAG_CLEAR 4'h8
`define CSB_CMD_BRANCH_SAME_HIGH  4'h9

// ==========================================================
// Status flag bit positions
`define CSB_FLAG_C 0
`define CSB_FLAG_Z 1
`define CSB_FLAG_N 2
`define CSB_FLAG_V 3
`define CSB_FLAG_H 5

// ==========================================================
// Reset values and cycle costs
`define CSB_PC_RESET    16'h0000
`define CSB_FLAGS_RESET 8'h00
`define CSB_COST_CALL   2'h3
`define CSB_COST_ONE    2'h1
`define CSB_COST_TWO    2'h2
`define CSB_PC_STEP     16'h0001

`endif

// >>> design/csb_compare.v
// Subtractor that produces compare flags without storing any result.
// Assumes operands come from same-clock register file reads.
`timescale 1ns/1ns
`default_nettype none

module csb_compare (
	input  wire [7:0] minuend,
	input  wire [7:0] subtrahend,
	output wire       zero,
	output wire       negative,
	output wire       overflow,
	output wire       carry,
	output wire       half_carry
);

	wire [8:0] diff;

	// ==========================================================
	// Flag generation
	assign diff       = {1'b0, minuend} - {1'b0, subtrahend};
	assign zero       = (diff[7:0] == 8'h00);
	assign negative   = diff[7];
	assign carry      = diff[8];
	assign overflow   = (minuend[7] & ~subtrahend[7] & ~diff[7]) |
	                    (~minuend[7] & subtrahend[7] & diff[7]);
	assign half_carry = (~minuend[3] & subtrahend[3]) | (subtrahend[3] & diff[3]) |
	                    (diff[3] & ~minuend[3]);

endmodule

`default_nettype wire

// >>> design/csb_unit.v
// Execution unit for indirect call, compare, skip and conditional branch commands.
// Assumes the core presents decoded operands with start, applies each stack byte when stack_write
// pulses and the pc and flag results when done pulses; all inputs come from logic on the same clock.
`include "csb_regs.vh"
`timescale 1ns/1ns
`default_nettype none

module csb_unit (
	input  wire                 clock,
	input  wire                 reset_n,
	input  wire                 start,
	input  wire [`CSB_CMD_W-1:0] command,
	input  wire [7:0]           reg_a,
	input  wire [7:0]           reg_b,
	input  wire [7:0]           immediate,
	input  wire [7:0]           io_value,
	input  wire [2:0]           bit_select,
	input  wire [6:0]           offset,
	input  wire [15:0]          pc,
	input  wire [15:0]          pointer,
	input  wire [7:0]           status_flags_register,
	input  wire                 next_is_two_word,
	output wire                 busy,
	output reg                  done,
	output reg                  pc_load,
	output reg  [15:0]          pc_value,
	output reg                  flags_write,
	output reg  [7:0]           flags_value,
	output reg                  stack_write,
	output reg  [7:0]           stack_data
);

	localparam ST_IDLE = 1'b0;
	localparam ST_EXEC = 1'b1;

	reg        state;
	reg [1:0]  cycles_left;
	reg [15:0] target;
	reg [15:0] return_addr;
	reg        is_call;
	reg        is_flag_update;
	reg [7:0]  flag_result;

	reg [1:0]  next_cost;
	reg [15:0] next_target;
	reg        next_flag_update;

	wire        cmp_z;
	wire        cmp_n;
	wire        cmp_v;
	wire        cmp_c;
	wire        cmp_h;
	wire [15:0] seq_pc;
	wire [15:0] skip_pc;
	wire [15:0] branch_pc;
	wire [7:0]  imm_flags;

	// ==========================================================
	// Bit selection used by register, io and flag tests.
	function pick_bit;
		input [7:0] value;
		input [2:0] sel;
		begin
			pick_bit = value[sel];
		end
	endfunction

	csb_compare u_compare (
		.minuend    (reg_a),
		.subtrahend (immediate),
		.zero       (cmp_z),
		.negative   (cmp_n),
		.overflow   (cmp_v),
		.carry      (cmp_c),
		.half_carry (cmp_h)
	);

	// ==========================================================
	// Target addresses. The offset is sign extended so backward branches wrap correctly.
	assign seq_pc    = pc + `CSB_PC_STEP;
	assign skip_pc   = pc + (next_is_two_word ? 16'h0003 : 16'h0002);
	assign branch_pc = pc + {{9{offset[6]}}, offset} + `CSB_PC_STEP;

	// Only the five compare flags are replaced; the sign flag and others are kept.
	assign imm_flags = {status_flags_register[7:6], cmp_h, status_flags_register[4],
	                    cmp_v, cmp_n, cmp_z, cmp_c};

	// Busy is decoded straight from the state, so a start that arrives while a
	// command runs is dropped; busy is already high in that cycle to tell the core.
	assign busy = (state == ST_EXEC);

	// ==========================================================
	// Command evaluation
	// A skip costs one cycle for the test plus one per skipped word. Codes that are not
	// decoded fall through as a one-word no-op.
	always @* begin
		next_cost        = `CSB_COST_ONE;
		next_target      = seq_pc;
		next_flag_update = 1'b0;
		case (command)
			`CSB_CMD_POINTER_CALL: begin
				next_cost   = `CSB_COST_CALL;
				next_target = pointer;
			end
			`CSB_CMD_COMPARE_SKIP_EQ: begin
				if (reg_a == reg_b) begin
					next_target = skip_pc;
					next_cost   = next_is_two_word ? `CSB_COST_CALL : `CSB_COST_TWO;
				end
			end
			`CSB_CMD_COMPARE_IMM: begin
				next_flag_update = 1'b1;
			end
			`CSB_CMD_SKIP_REG_CLEAR: begin
				if (!pick_bit(reg_a, bit_select)) begin
					next_target = skip_pc;
					next_cost   = next_is_two_word ? `CSB_COST_CALL : `CSB_COST_TWO;
				end
			end
			`CSB_CMD_SKIP_REG_SET: begin
				if (pick_bit(reg_a, bit_select)) begin
					next_target = skip_pc;
					next_cost   = next_is_two_word ? `CSB_COST_CALL : `CSB_COST_TWO;
				end
			end
			`CSB_CMD_SKIP_IO_SET: begin
				if (pick_bit(io_value, bit_select)) begin
					next_target = skip_pc;
					next_cost   = next_is_two_word ? `CSB_COST_CALL : `CSB_COST_TWO;
				end
			end
			`CSB_CMD_BRANCH_FLAG_SET: begin
				if (pick_bit(status_flags_register, bit_select)) begin
					next_target = branch_pc;
					next_cost   = `CSB_COST_TWO;
				end
			end
			`CSB_CMD_BRANCH_FLAG_CLEAR: begin
				if (!pick_bit(status_flags_register, bit_select)) begin
					next_target = branch_pc;
					next_cost   = `CSB_COST_TWO;
				end
			end
			`CSB_CMD_BRANCH_SAME_HIGH: begin
				if (!status_flags_register[`CSB_FLAG_C]) begin
					next_target = branch_pc;
					next_cost   = `CSB_COST_TWO;
				end
			end
			default: begin
				next_cost = `CSB_COST_ONE;
			end
		endcase
	end

	// ==========================================================
	// Sequencer. Unknown commands still complete in one cycle so the core never hangs.
	always @(posedge clock) begin
		if (!reset_n) begin
			state          <= ST_IDLE;
			cycles_left    <= 2'h0;
			target         <= `CSB_PC_RESET;
			return_addr    <= `CSB_PC_RESET;
			is_call        <= 1'b0;
			is_flag_update <= 1'b0;
			flag_result    <= `CSB_FLAGS_RESET;
			done           <= 1'b0;
			pc_load        <= 1'b0;
			pc_value       <= `CSB_PC_RESET;
			flags_write    <= 1'b0;
			flags_value    <= `CSB_FLAGS_RESET;
			stack_write    <= 1'b0;
			stack_data     <= 8'h00;
		end else begin
			done        <= 1'b0;
			pc_load     <= 1'b0;
			flags_write <= 1'b0;
			stack_write <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (start) begin
						// All operands are taken on this edge only; the core may reuse them.
						state          <= ST_EXEC;
						cycles_left    <= next_cost - 2'h1;
						target         <= next_target;
						return_addr    <= seq_pc;
						is_call        <= (command == `CSB_CMD_POINTER_CALL);
						is_flag_update <= next_flag_update;
						flag_result    <= imm_flags;
					end
				end
				ST_EXEC: begin
					// The return address goes out low byte first, before the jump.
					if (is_call && cycles_left == 2'h2) begin
						stack_write <= 1'b1;
						stack_data  <= return_addr[7:0];
					end
					if (is_call && cycles_left == 2'h1) begin
						stack_write <= 1'b1;
						stack_data  <= return_addr[15:8];
					end
					if (cycles_left == 2'h0) begin
						state       <= ST_IDLE;
						done        <= 1'b1;
						pc_load     <= 1'b1;
						pc_value    <= target;
						flags_write <= is_flag_update;
						// The flag copy is held otherwise, so skips never disturb it.
						if (is_flag_update) begin
							flags_value <= flag_result;
						end
					end else begin
						cycles_left <= cycles_left - 2'h1;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

endmodule

`default_nettype wire

// >>> test/csb_chk_asserts.sv
// Checker for the compare, skip and branch unit.
// Assumes it is bound to csb_unit and sees only its ports.
`include "csb_regs.vh"
`timescale 1ns/1ns
`default_nettype none
module csb_chk (
	input wire logic        clock,
	input wire logic        reset_n,
	input wire logic        start,
	input wire logic        busy,
	input wire logic [3:0]  command,
	input wire logic [7:0]  reg_a,
	input wire logic [7:0]  reg_b,
	input wire logic [7:0]  immediate,
	input wire logic [2:0]  bit_select,
	input wire logic [6:0]  offset,
	input wire logic [15:0] pc,
	input wire logic [15:0] pointer,
	input wire logic [7:0]  status_flags_register,
	input wire logic        next_is_two_word,
	input wire logic        done,
	input wire logic        pc_load,
	input wire logic [15:0] pc_value,
	input wire logic        flags_write,
	input wire logic [7:0]  flags_value,
	input wire logic        stack_write,
	input wire logic [7:0]  stack_data
);
	// ==========================================================
	// Operand capture
	// Operands are kept from the taking edge, since the core may change them while busy.
	wire        tk   = start && !busy;
	wire        fbit = status_flags_register[bit_select];
	reg  [15:0] t_pc1;
	reg  [15:0] t_ptr;
	reg  [7:0]  t_a;
	reg  [7:0]  t_i;
	reg  [6:0]  t_off;
	reg  [3:0]  t_cmd;
	wire [15:0] tgt  = t_pc1 + {{9{t_off[6]}}, t_off};
	always @(posedge clock) begin
		if (tk) begin
			t_pc1 <= pc + 16'h0001;
			t_ptr <= pointer;
			t_a <= reg_a;
			t_i <= immediate;
			t_off <= offset;
			t_cmd <= command;
		end
	end
	// ==========================================================
	// Properties
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	call_order_a: assert property (tk && command == `CSB_CMD_POINTER_CALL |=> ##1 stack_write
		&& stack_data == t_pc1[7:0] ##1 stack_write && stack_data == t_pc1[15:8]
		##1 done && pc_value == t_ptr) else $error("call order");
	compare_skip_equal_skip_a: assert property (tk && command == `CSB_CMD_COMPARE_SKIP_EQ && reg_a == reg_b
		&& next_is_two_word |=> !done [*3] ##1 done && pc_value == t_pc1 + 16'h0002)
		else $error("compare_skip_equal skip");
	cmp_imm_a: assert property (tk && command == `CSB_CMD_COMPARE_IMM |=> !done ##1 done
		&& flags_write && pc_value == t_pc1 && flags_value[`CSB_FLAG_Z] == (t_a == t_i)
		&& flags_value[`CSB_FLAG_C] == (t_a < t_i)) else $error("cmp imm");
	skip_clr_a: assert property (tk && command == `CSB_CMD_SKIP_REG_CLEAR && !reg_a[bit_select]
		&& !next_is_two_word |=> !done [*2] ##1 done && pc_value == t_pc1 + 16'h0001)
		else $error("skip clear");
	flag_owner_a: assert property (flags_write |-> t_cmd == `CSB_CMD_COMPARE_IMM)
		else $error("flags write");
	br_set_a: assert property (tk && command == `CSB_CMD_BRANCH_FLAG_SET && fbit
		|=> !done [*2] ##1 done && pc_value == tgt) else $error("branch set");
	br_clr_a: assert property (tk && command == `CSB_CMD_BRANCH_FLAG_CLEAR && fbit
		|=> !done ##1 done && pc_value == t_pc1) else $error("branch clear");
	br_same_a: assert property (tk && command == `CSB_CMD_BRANCH_SAME_HIGH
		&& !status_flags_register[`CSB_FLAG_C] |=> !done [*2] ##1 done && pc_value == tgt)
		else $error("branch same");
	skip_set_a: assert property (tk && command == `CSB_CMD_SKIP_REG_SET && reg_a[bit_select]
		&& next_is_two_word |=> !done [*3] ##1 done && pc_value == t_pc1 + 16'h0002)
		else $error("skip set");
	load_pulse_a: assert property (pc_load == done) else $error("pc load");
endmodule
bind csb_unit csb_chk u_chk (.*);
`default_nettype wire

// >>> test/compare_skip_branch_unit_bench.sv
// Self-checking bench for the compare, skip and branch unit.
// Assumes csb_unit and its checker are compiled ahead of it.
`include "csb_regs.vh"
`timescale 1ns/1ns
`default_nettype none
module compare_skip_branch_unit_bench;
	localparam [7:0] PAT = 8'h5A;
	logic        clock = 1'h0, reset_n = 1'h0, start = 1'h0, next_is_two_word = 1'h0;
	logic [3:0]  command = 4'h0;
	logic [7:0]  reg_a = 8'h01, reg_b = 8'h00, immediate = 8'h00, io_value = 8'h00;
	logic [7:0]  status_flags_register = 8'h00;
	logic [2:0]  bit_select = 3'h0;
	logic [6:0]  offset = 7'h00;
	logic [15:0] pc = 16'h0000, pointer = 16'h0000, pushed, exp_pc;
	wire         busy, done, pc_load, flags_write, stack_write;
	wire  [15:0] pc_value;
	wire  [7:0]  flags_value, stack_data;
	integer      n_fail = 0, check_count = 0, i, k, e, f;
	csb_unit u_dut (.*);
	always #10 clock = ~clock;
	// ==========================================================
	// Shared tasks
	task chk(input [15:0] seen, input [15:0] exp);
		begin
			check_count = check_count + 1;
			if (seen !== exp) begin
				n_fail = n_fail + 1;
				$display("BAD %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	// Pulses start, counts cycles up to done and checks count and new pc.
	task run(input [3:0] c, input [15:0] xpc, input integer xn);
		integer n;
		begin
			command <= c;
			start <= 1'h1;
			@(posedge clock);
			start <= 1'h0;
			n = 0;
			do begin
				@(posedge clock);
				#1;
				n = n + 1;
				if (n == 1) chk(busy, xn > 1);
				if (stack_write === 1'h1) pushed = {stack_data, pushed[15:8]};
			end while (n < 5 && done !== 1'h1);
			chk(n[15:0], xn[15:0]);
			chk(pc_value, xpc);
			chk(pc_load, 1'h1);
			chk(flags_write, c == `CSB_CMD_COMPARE_IMM);
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d mismatches %0d", check_count, n_fail);
			if (n_fail == 0 && check_count > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	// ==========================================================
	// Scenarios
	task t_call;
		begin
			@(posedge clock);
			pc <= 16'h1234;
			pointer <= 16'hABCD;
			run(`CSB_CMD_POINTER_CALL, 16'hABCD, 3);
			chk(pushed, 16'h1235);
			@(posedge clock);
			run(4'hF, 16'h1235, 1);
		end
	endtask
	// A reset applied while the unit is idle must clear every pulse and the held outputs.
	task t_reset;
		begin
			@(posedge clock);
			reset_n <= 1'h0;
			repeat (2) @(posedge clock);
			#1;
			chk({busy, done, pc_load, flags_write, stack_write}, 16'h0000);
			chk(pc_value, `CSB_PC_RESET);
			chk({flags_value, stack_data}, 16'h0000);
			@(posedge clock);
			reset_n <= 1'h1;
		end
	endtask
	// Borrow out of bit 3 sets the half flag; bits 4, 6 and 7 are copied.
	task t_cpi;
		begin
			@(posedge clock);
			reg_a <= 8'h10;
			immediate <= 8'h01;
			status_flags_register <= 8'hD0;
			run(`CSB_CMD_COMPARE_IMM, 16'h1235, 1);
			chk({8'h00, flags_value}, 16'h00F0);
			@(posedge clock);
			reg_a <= 8'h01;
			immediate <= 8'h02;
			status_flags_register <= 8'h00;
			run(`CSB_CMD_COMPARE_IMM, 16'h1235, 1);
			chk({8'h00, flags_value}, 16'h0025);
		end
	endtask
	task t_compare_skip_equal;
		for (i = 0; i < 3; i = i + 1) begin
			@(posedge clock);
			reg_b <= (i == 2) ? 8'h02 : 8'h01;
			next_is_two_word <= (i == 1);
			e = (i == 2) ? 1 : i + 2;
			run(`CSB_CMD_COMPARE_SKIP_EQ, 16'h1234 + e[15:0], e);
		end
	endtask
	task t_bits;
		for (k = 4; k < 7; k = k + 1) for (i = 0; i < 8; i = i + 1) begin
			@(posedge clock);
			reg_a <= PAT;
			io_value <= PAT;
			bit_select <= i[2:0];
			next_is_two_word <= i[0];
			e = (PAT[i] ^ (k == 4)) ? 2 + i % 2 : 1;
			run(k[3:0], 16'h1234 + e[15:0], e);
		end
	endtask
	// Offsets at both ends of the signed range catch a missing sign extension.
	task t_branch;
		for (k = 7; k < 10; k = k + 1) for (i = 0; i < 8; i = i + 1) begin
			@(posedge clock);
			status_flags_register <= PAT ^ {8{i[1]}};
			bit_select <= i[2:0];
			offset <= i[0] ? 7'h40 : 7'h3F;
			pc <= 16'h0100;
			f = PAT[(k == 9) ? 0 : i] ^ i[1];
			e = ((k == 7) ? f : !f) ? 2 : 1;
			exp_pc = (e == 1) ? 16'h0101 : (i[0] ? 16'h00C1 : 16'h0140);
			run(k[3:0], exp_pc, e);
		end
	endtask
	initial begin
		repeat (8) @(posedge clock);
		reset_n <= 1'h1;
		t_call;
		t_cpi;
		t_reset;
		t_compare_skip_equal;
		t_bits;
		t_branch;
		finish_test;
	end
	initial begin
		#100000;
		n_fail = n_fail + 1;
		finish_test;
	end
endmodule
`default_nettype wire
